// ==== hdl/sisup_pkg.sv ====
/*
  constants and types for the safety interlock supervisor.
  assumes one 50 MHz clock and switch inputs already on that clock.
*/
package sisup_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned DISC_TIME_S = 2;
  // least time, whole seconds need no rounding
  localparam int unsigned DISC_CYC    = DISC_TIME_S * CLK_HZ;
  localparam int unsigned DISC_W      = 27;

  typedef enum logic [1:0] {
    SISUP_RUN   = 2'b00,
    SISUP_HALT  = 2'b01,
    SISUP_FREED = 2'b10
  } sisup_halt_type;
endpackage

// ==== hdl/sisup_top.sv ====
/*
  safety interlock supervisor: discrepancy timers, condition latches
  and the halt state machine.
  assumes all switch levels are synchronous to core_clk; reset is held
  at least one edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sisup_top
  import sisup_pkg::*;
#(
  parameter int unsigned DISC_LIMIT = DISC_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // door and stop channels, high = contact closed
  input  wire logic door_ch1,
  input  wire logic door_ch2,
  input  wire logic stop_ch1,
  input  wire logic stop_ch2,
  input  wire logic stop_conn,
  input  wire logic latch_release,
  // pendant and link
  input  wire logic pendant_port,
  input  wire logic pendant_key_prog,
  input  wire logic link_active,
  input  wire logic link_disconnect,
  input  wire logic reset_cmd,
  // status
  output logic      halt_status_flag,
  output logic      halt_lamp,
  output logic      door_safety_flag,
  output logic      prog_mode,
  output logic      run_allowed,
  output logic      power_prohibit,
  output logic      program_hold,
  output logic      critical_error,
  output logic      pendant_cfg_pulse
);

  typedef struct packed {
    logic [1:0]        door_s1;
    logic [1:0]        door_s2;
    logic [1:0]        stop_s1;
    logic [1:0]        stop_s2;
    logic [1:0]        conn_s;
    logic [1:0]        rel_s;
    logic [1:0]        pend_s;
    logic [1:0]        key_s;
    logic [1:0]        link_s;
    logic              pend_seen;
    logic              link_seen;
    logic [DISC_W-1:0] door_cnt;
    logic [DISC_W-1:0] stop_cnt;
    logic              crit;
    logic              door_latch;
    logic              prog_latch;
    sisup_halt_type    halt;
    logic              cfg;
  } sisup_state_type;

  sisup_state_type st_reg;
  sisup_state_type st_next;

  function automatic logic [DISC_W-1:0] disc_step(
    input logic [DISC_W-1:0] cnt,
    input logic              a,
    input logic              b
  );
    if (a == b) begin
      disc_step = '0;
    end else if (cnt < DISC_W'(DISC_LIMIT)) begin
      disc_step = cnt + DISC_W'(1);
    end else begin
      disc_step = cnt;
    end
  endfunction

  logic door_open;
  logic stop_req;
  logic link_lost;
  logic prog_now;

  // --------------------------------------------------------------
  // derived levels
  // --------------------------------------------------------------
  always_comb begin
    // door open when either channel opens
    door_open = !(st_reg.door_s1[1] && st_reg.door_s2[1]);
    // normally closed contacts: any open channel requests stop
    stop_req  = !(st_reg.stop_s1[1] && st_reg.stop_s2[1]);
    // link dropped while a session was up, no disconnect
    link_lost = st_reg.link_seen && !st_reg.link_s[1];
    // key only counts while pendant present, else latch holds
    prog_now  = st_reg.pend_s[1] && st_reg.key_s[1];
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic halt_cause;
    halt_cause = 1'b0;
    st_next = st_reg;
    // two-stage synchronisers, stage 0 read only by stage 1
    st_next.door_s1 = {st_reg.door_s1[0], door_ch1};
    st_next.door_s2 = {st_reg.door_s2[0], door_ch2};
    st_next.stop_s1 = {st_reg.stop_s1[0], stop_ch1};
    st_next.stop_s2 = {st_reg.stop_s2[0], stop_ch2};
    st_next.conn_s  = {st_reg.conn_s[0], stop_conn};
    st_next.rel_s   = {st_reg.rel_s[0], latch_release};
    st_next.pend_s  = {st_reg.pend_s[0], pendant_port};
    st_next.key_s   = {st_reg.key_s[0], pendant_key_prog};
    st_next.link_s  = {st_reg.link_s[0], link_active};

    // one-cycle configure pulse on each attach, also at boot
    st_next.pend_seen = st_reg.pend_s[1];
    st_next.cfg       = st_reg.pend_s[1] && !st_reg.pend_seen;

    // session armed while up; orderly disconnect disarms it
    if (link_disconnect) begin
      st_next.link_seen = 1'b0;
    end else if (st_reg.link_s[1]) begin
      st_next.link_seen = 1'b1;
    end

    st_next.door_cnt = disc_step(st_reg.door_cnt, st_reg.door_s1[1],
                                 st_reg.door_s2[1]);
    st_next.stop_cnt = disc_step(st_reg.stop_cnt, st_reg.stop_s1[1],
                                 st_reg.stop_s2[1]);
    // critical error is sticky until reset: a wiring fault needs service
    if (st_reg.door_cnt >= DISC_W'(DISC_LIMIT) ||
        st_reg.stop_cnt >= DISC_W'(DISC_LIMIT)) begin
      st_next.crit = 1'b1;
    end

    // latches; set dominates while release open
    // release closed clears; open door re-sets at once
    if (door_open) begin
      st_next.door_latch = 1'b1;
    end else if (st_reg.rel_s[1]) begin
      st_next.door_latch = 1'b0;
    end
    // clears only once key is back to run and release closed
    if (prog_now) begin
      st_next.prog_latch = 1'b1;
    end else if (st_reg.rel_s[1] && st_reg.pend_s[1]) begin
      st_next.prog_latch = 1'b0;
    end

    halt_cause = stop_req || !st_reg.pend_s[1] || !st_reg.conn_s[1] ||
                 link_lost;
    // release first, then reset; reset during stop is ignored
    case (st_reg.halt)
      SISUP_RUN: begin
        if (halt_cause) begin
          st_next.halt = SISUP_HALT;
        end
      end
      SISUP_HALT: begin
        if (!halt_cause) begin
          st_next.halt = SISUP_FREED;
        end
      end
      SISUP_FREED: begin
        if (halt_cause) begin
          st_next.halt = SISUP_HALT;
        end else if (reset_cmd) begin
          st_next.halt = SISUP_RUN;
        end
      end
      default: begin
        st_next.halt = SISUP_HALT;
      end
    endcase
    // a lost link is cleared by the reset command or by relinking
    if (st_reg.halt != SISUP_RUN && reset_cmd && !stop_req &&
        link_lost) begin
      st_next.link_seen = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg            <= '0;
      // power-up stop: start halted until proven clear
      st_reg.halt       <= SISUP_HALT;
      // assume door open at boot until the latch is released
      st_reg.door_latch <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // lamp and flag follow the halt state
  assign halt_status_flag  = (st_reg.halt != SISUP_RUN);
  assign halt_lamp         = (st_reg.halt != SISUP_RUN);
  // door-safety flag is the door latch
  assign door_safety_flag  = st_reg.door_latch;
  // programming mode held by the latch
  assign prog_mode         = st_reg.prog_latch;
  // open door prohibits power whatever the prog latch does
  assign power_prohibit    = st_reg.door_latch || door_open ||
                             st_reg.halt != SISUP_RUN || st_reg.crit;
  assign program_hold      = power_prohibit;
  // production run refused in programming mode or fault
  assign run_allowed       = !power_prohibit && !st_reg.prog_latch &&
                             st_reg.conn_s[1];
  assign critical_error    = st_reg.crit;
  assign pendant_cfg_pulse = st_reg.cfg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_stop_forces_halt: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(st_reg.stop_s1[1]) |=> halt_status_flag)
    else $error("open stop channel did not halt");

  a_no_pendant_halt: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !st_reg.pend_s[1] |=> halt_status_flag)
    else $error("halt not held without pendant");

  a_reset_needed: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(halt_status_flag) |-> $past(reset_cmd) && !$past(stop_req))
    else $error("halt left without release and reset");

  a_lamp_flag_pair: assert property (
    @(posedge core_clk) disable iff (!rstn)
    halt_lamp == halt_status_flag)
    else $error("lamp and halt flag differ");

  a_door_prohibit: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !st_reg.door_s1[1] |-> power_prohibit && program_hold)
    else $error("open door left power allowed");

  a_door_latch_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    door_safety_flag && !st_reg.rel_s[1] |=> door_safety_flag)
    else $error("door latch dropped with release open");

  a_latch_release: assert property (
    @(posedge core_clk) disable iff (!rstn)
    st_reg.rel_s[1] && !door_open |=> !door_safety_flag)
    else $error("door latch not released");

  a_prog_keeps: assert property (
    @(posedge core_clk) disable iff (!rstn)
    prog_mode && !st_reg.pend_s[1] |=> prog_mode && !run_allowed)
    else $error("programming mode lost on pendant removal");

  a_door_disc: assert property (
    @(posedge core_clk) disable iff (!rstn)
    st_reg.door_cnt == DISC_W'(DISC_LIMIT) |=> critical_error)
    else $error("door discrepancy not flagged");

  a_link_loss: assert property (
    @(posedge core_clk) disable iff (!rstn)
    link_lost |=> halt_status_flag)
    else $error("lost link did not halt");

  a_attach_cfg: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(st_reg.pend_s[1]) |=> pendant_cfg_pulse ##1 !pendant_cfg_pulse)
    else $error("no configure pulse on attach");

  a_stop_disc: assert property (
    @(posedge core_clk) disable iff (!rstn)
    st_reg.stop_cnt == DISC_W'(DISC_LIMIT) |=> critical_error)
    else $error("stop discrepancy not flagged");

  a_halt_while_stop: assert property (
    @(posedge core_clk) disable iff (!rstn)
    halt_status_flag && stop_req |=> halt_status_flag)
    else $error("halt left while stop requested");

  a_crit_sticky: assert property (
    @(posedge core_clk) disable iff (!rstn)
    critical_error |=> critical_error)
    else $error("critical error dropped");

  a_prog_blocks_run: assert property (
    @(posedge core_clk) disable iff (!rstn)
    prog_mode |-> !run_allowed)
    else $error("run allowed in programming mode");

  a_prog_door_power: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(prog_mode) && door_open |-> power_prohibit)
    else $error("power allowed with door open");

  a_conn_fault: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !st_reg.conn_s[1] |=> halt_status_flag && !run_allowed)
    else $error("missing stop connection not a fault");

  a_door_sets_flag: assert property (
    @(posedge core_clk) disable iff (!rstn)
    door_open |=> door_safety_flag)
    else $error("open door did not set safety flag");

  a_cfg_single: assert property (
    @(posedge core_clk) disable iff (!rstn)
    pendant_cfg_pulse |=> !pendant_cfg_pulse)
    else $error("configure pulse longer than one cycle");
endmodule
`default_nettype wire

// ==== bench/sisup_field.sv ====
/*
  switch-side model: door switch, stop button and pendant.
  assumes the bench sets its controls at core_clk rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module sisup_field (
  // controls
  input  wire logic door_shut,
  input  wire logic door_skew,
  input  wire logic stop_free,
  input  wire logic stop_skew,
  input  wire logic pend_in,
  input  wire logic key_prog,
  // contacts
  output logic      door_ch1,
  output logic      door_ch2,
  output logic      stop_ch1,
  output logic      stop_ch2,
  output logic      pendant_port,
  output logic      pendant_key_prog
);
  assign door_ch1 = door_shut;
  assign door_ch2 = door_shut ^ door_skew;
  assign stop_ch1 = stop_free;
  assign stop_ch2 = stop_free ^ stop_skew;
  // key line reads the inverted key while pendant is out
  assign pendant_port     = pend_in;
  assign pendant_key_prog = pend_in ? key_prog : ~key_prog;
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
  self-checking bench for the interlock supervisor.
  assumes outputs settle three edges after an input change.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rstn = 1'b0;
  logic shut = 1'b1, dsk = 1'b0, sfree = 1'b1, ssk = 1'b0;
  logic pin = 1'b1, key = 1'b0, conn = 1'b1, lrel = 1'b1;
  logic lact = 1'b0, ldis = 1'b0, rcmd = 1'b0;
  wire logic d1, d2, s1, s2, pp, pk;
  logic halt, lamp, dsf, prog, run, pwr, hold, crit, cfg;
  int err_total = 0, num_checks = 0;
  initial forever #10 core_clk = ~core_clk;
  sisup_field sisup_field_inst (.door_shut(shut), .door_skew(dsk),
    .stop_free(sfree), .stop_skew(ssk), .pend_in(pin), .key_prog(key),
    .door_ch1(d1), .door_ch2(d2), .stop_ch1(s1), .stop_ch2(s2),
    .pendant_port(pp), .pendant_key_prog(pk));
  // short discrepancy window keeps the run brief
  sisup_top #(.DISC_LIMIT(20)) sisup_top_inst (.core_clk(core_clk),
    .rstn(rstn), .door_ch1(d1), .door_ch2(d2), .stop_ch1(s1),
    .stop_ch2(s2), .stop_conn(conn), .latch_release(lrel),
    .pendant_port(pp), .pendant_key_prog(pk), .link_active(lact),
    .link_disconnect(ldis), .reset_cmd(rcmd), .halt_status_flag(halt),
    .halt_lamp(lamp), .door_safety_flag(dsf), .prog_mode(prog),
    .run_allowed(run), .power_prohibit(pwr), .program_hold(hold),
    .critical_error(crit), .pendant_cfg_pulse(cfg));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic seen, input logic exp, input string m);
    #1;
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic pulse_reset;
    rcmd <= 1'b1;
    tick(1);
    rcmd <= 1'b0;
    tick(4);
  endtask
  // power-up, then release and reset command
  task automatic t_boot;
    int seen = 0;
    rstn <= 1'b0;
    tick(4);
    chk(lamp, 1'b1, "lamp at reset");
    chk(dsf, 1'b1, "door flag at boot");
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      tick(1);
      #1 if (cfg === 1'b1) seen++;
    end
    chk(seen == 1, 1'b1, "one cfg pulse");
    chk(halt, 1'b1, "release alone");
    pulse_reset();
    chk(halt, 1'b0, "halt cleared");
    chk(run, 1'b1, "run allowed");
    $display("boot done");
  endtask
  task automatic t_stop;
    sfree <= 1'b0;
    tick(4);
    chk(halt, 1'b1, "stop halt");
    pulse_reset();
    chk(halt, 1'b1, "reset while pressed");
    sfree <= 1'b1;
    tick(4);
    pulse_reset();
    chk(lamp, 1'b0, "lamp off");
    conn <= 1'b0;
    tick(4);
    chk(run, 1'b0, "no connector");
    conn <= 1'b1;
    pin <= 1'b0;
    tick(4);
    chk(halt, 1'b1, "no pendant");
    pin <= 1'b1;
    tick(4);
    pulse_reset();
    lact <= 1'b1;
    tick(4);
    lact <= 1'b0;
    tick(4);
    chk(halt, 1'b1, "link lost");
    pulse_reset();
    pulse_reset();
    lact <= 1'b1;
    tick(4);
    ldis <= 1'b1;
    tick(4);
    lact <= 1'b0;
    tick(4);
    chk(halt, 1'b0, "orderly disconnect");
    ldis <= 1'b0;
    $display("stop done");
  endtask
  task automatic t_latch;
    lrel <= 1'b0;
    shut <= 1'b0;
    key <= 1'b1;
    tick(4);
    chk(hold, 1'b1, "door hold");
    pin <= 1'b0;
    tick(4);
    chk(prog, 1'b1, "prog kept unplugged");
    pin <= 1'b1;
    key <= 1'b0;
    shut <= 1'b1;
    tick(4);
    chk(dsf, 1'b1, "door latched");
    chk(prog, 1'b1, "prog latched");
    shut <= 1'b0;
    lrel <= 1'b1;
    tick(4);
    chk(prog, 1'b0, "prog released");
    chk(pwr, 1'b1, "door still open");
    shut <= 1'b1;
    tick(4);
    chk(dsf, 1'b0, "door released");
    $display("latch done");
  endtask
  // skew below the window, then beyond it
  task automatic t_skew(input logic on_door);
    dsk <= on_door;
    ssk <= ~on_door;
    tick(15);
    dsk <= 1'b0;
    ssk <= 1'b0;
    tick(4);
    chk(crit, 1'b0, "short skew");
    dsk <= on_door;
    ssk <= ~on_door;
    tick(30);
    chk(crit, 1'b1, "long skew");
    chk(pwr, 1'b1, "crit prohibits");
    dsk <= 1'b0;
    ssk <= 1'b0;
    $display("skew done");
  endtask
  initial begin
    t_boot();
    t_stop();
    t_latch();
    t_skew(1'b1);
    t_boot();
    t_skew(1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
